// *** design/video_pixel_output.sv ***
// Video pixel output stage with window tags on the sync pins.
// Assumes an APB master on core_clk and a pixel source that
// supplies each word with its depth, tag, cursor and blank flags.
//
// Notes on behaviour
// - One bit per pixel: bitmap on pin zero, padding on the other seven.
// - Two or four bits: bitmap on the lowest pins, padding above them.
// - Eight bits per pixel: all pins from the bitmap, no padding.
// - Blanking and reset put the blank-time pixel value on the pins.
// - Outside the cursor, two tag bits follow the window being scanned.
// - Where the cursor is shown its own tag replaces the window tag.
// - With tags enabled, visible time shows tags on the sync pins.
// - Config bit 4 enables tag multiplexing onto the sync pins.
// - With tags disabled, both sync pins stay low in visible time.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module video_pixel_output
    import video_out_pkg::*;
#(
    parameter int BUF_DEPTH = BUF_DEPTH_DEF
)(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              inValid,
    output logic                   inReady,
    input  wire logic [7:0]        inBits,
    input  wire logic [1:0]        inDepth,
    input  wire logic [1:0]        inTag,
    input  wire logic              inCursor,
    input  wire logic              inBlank,
    input  wire logic              inHsync,
    input  wire logic              inVsync,
    input  wire logic              pixelAdvance,
    output logic [7:0]             pixelDataPins,
    output logic                   blankOut,
    output logic                   hsyncOut,
    output logic                   vsyncOut
);
    localparam int CW = $clog2(BUF_DEPTH+1);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  pins;
        logic        blank;
        logic        hs;
        logic        vs;
        logic        tagEn;
        logic [7:0]  blankVal;
        logic [7:0]  pad;
        logic [1:0]  curTag;
        logic [1:0]  lastTag;
        logic        underrun;
        logic [31:0] rdata;
        logic        err;
    } top_state_type;

    localparam top_state_type STATE_RST = '{
        pins:     BLANKV_RST,
        blank:    1'b1,
        hs:       1'b0,
        vs:       1'b0,
        tagEn:    TAG_EN_RST,
        blankVal: BLANKV_RST,
        pad:      PAD_RST,
        curTag:   CURTAG_RST,
        lastTag:  2'h0,
        underrun: 1'b0,
        rdata:    32'h0000_0000,
        err:      1'b0
    };

    top_state_type q;
    top_state_type d;

    // ---------------------------------------------------------------
    // Stream buffer
    // ---------------------------------------------------------------
    pixel_stream_if #(.WIDTH(PIX_W)) inLink ();
    pixel_stream_if #(.WIDTH(PIX_W)) outLink ();

    logic [CW-1:0] fill;
    pixel_type     pix;
    logic [7:0]    fmtPins;
    logic          take;
    logic          under;
    logic [1:0]    effTag;

    assign inLink.valid = inValid;
    assign inLink.data  = {inBits, depth_type'(inDepth), inTag,
                           inCursor, inBlank, inHsync, inVsync};
    assign inReady      = inLink.ready;

    two_entry_buffer #(
        .WIDTH (PIX_W),
        .DEPTH (BUF_DEPTH)
    ) pixelBuffer (
        .clk     (core_clk),
        .rstn    (rstn),
        .inPort  (inLink),
        .outPort (outLink),
        .fill    (fill)
    );

    assign pix           = pixel_type'(outLink.data);
    assign outLink.ready = pixelAdvance;
    assign take          = pixelAdvance && outLink.valid;
    assign under         = pixelAdvance && !outLink.valid;

    pixel_formatter pixelFormat (
        .depth (pix.depth),
        .bits  (pix.bits),
        .pad   (q.pad),
        .pins  (fmtPins)
    );

    // Cursor tag overrides the window's tag
    assign effTag = pix.cursor ? q.curTag : pix.tag;

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    logic setup;
    logic access;
    logic wrAcc;
    logic mapped;

    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign wrAcc  = access && pwrite;
    assign mapped = (paddr == OFF_CONFIG) || (paddr == OFF_BLANKV) ||
                    (paddr == OFF_PAD)    || (paddr == OFF_CURTAG) ||
                    (paddr == OFF_STATUS);

    assign pready  = 1'b1;
    assign pslverr = access && q.err;
    assign prdata  = q.rdata;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        d = q;

        // Read data and error are captured in the setup cycle
        if (setup)
        begin
            d.err   = !mapped;
            d.rdata = 32'h0000_0000;
            if (paddr == OFF_CONFIG)
                d.rdata[TAG_EN_BIT] = q.tagEn;
            else if (paddr == OFF_BLANKV)
                d.rdata[7:0] = q.blankVal;
            else if (paddr == OFF_PAD)
                d.rdata[7:0] = q.pad;
            else if (paddr == OFF_CURTAG)
                d.rdata[1:0] = q.curTag;
            else if (paddr == OFF_STATUS)
            begin
                d.rdata[ST_UNDERRUN] = q.underrun;
                d.rdata[ST_BLANK]    = q.blank;
                d.rdata[ST_TAG_LSB+1:ST_TAG_LSB] = q.lastTag;
                d.rdata[ST_FILL_LSB+CW-1:ST_FILL_LSB] = fill;
            end
        end

        // Writes land at the access edge
        if (wrAcc)
        begin
            if (paddr == OFF_CONFIG)
                d.tagEn = pwdata[TAG_EN_BIT];
            else if (paddr == OFF_BLANKV)
                d.blankVal = pwdata[7:0];
            else if (paddr == OFF_PAD)
                d.pad = pwdata[7:0];
            else if (paddr == OFF_CURTAG)
                d.curTag = pwdata[1:0];
        end

        // Sticky underrun, a new event beats the clear
        if (wrAcc && paddr == OFF_STATUS && pwdata[ST_UNDERRUN])
            d.underrun = 1'b0;
        if (under)
            d.underrun = 1'b1;

        // Pixel pins, tags and blank move together when a word is taken
        if (take)
        begin
            d.blank   = pix.blank;
            d.lastTag = effTag;
            if (pix.blank)
            begin
                d.pins = q.blankVal;
                d.hs   = pix.hsync;
                d.vs   = pix.vsync;
            end
            else
            begin
                d.pins = fmtPins;
                d.hs   = q.tagEn && effTag[0];
                d.vs   = q.tagEn && effTag[1];
            end
        end
        else if (under)
        begin
            // Starved source shows blank value, syncs keep level
            d.blank = 1'b1;
            d.pins  = q.blankVal;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            q <= STATE_RST;
        else
            q <= d;
    end

    assign pixelDataPins = q.pins;
    assign blankOut      = q.blank;
    assign hsyncOut      = q.hs;
    assign vsyncOut      = q.vs;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    blank_value_a: assert property (
        (take && pix.blank) |=>
            (pixelDataPins == $past(q.blankVal)) && blankOut)
        else $error("blank time pins differ from blank value");

    one_bit_pad_a: assert property (
        (take && !pix.blank && pix.depth == DEPTH1) |=>
            pixelDataPins == {$past(q.pad[7:1]), $past(pix.bits[0])})
        else $error("one bit pixel not on pin zero with padding");

    two_bit_pad_a: assert property (
        (take && !pix.blank && pix.depth == DEPTH2) |=>
            pixelDataPins == {$past(q.pad[7:2]), $past(pix.bits[1:0])})
        else $error("two bit pixel mapping wrong");

    four_bit_pad_a: assert property (
        (take && !pix.blank && pix.depth == DEPTH4) |=>
            pixelDataPins == {$past(q.pad[7:4]), $past(pix.bits[3:0])})
        else $error("four bit pixel mapping wrong");

    eight_bit_a: assert property (
        (take && !pix.blank && pix.depth == DEPTH8) |=>
            pixelDataPins == $past(pix.bits))
        else $error("eight bit pixel was padded");

    sync_low_a: assert property (
        (take && !pix.blank && !q.tagEn) |=>
            !hsyncOut && !vsyncOut && !blankOut)
        else $error("sync pins not low in visible time");

    tag_on_sync_a: assert property (
        (take && !pix.blank && q.tagEn && !pix.cursor) |=>
            {vsyncOut, hsyncOut} == $past(pix.tag))
        else $error("window tag missing on sync pins");

    cursor_tag_a: assert property (
        (take && !pix.blank && q.tagEn && pix.cursor) |=>
            {vsyncOut, hsyncOut} == $past(q.curTag))
        else $error("cursor tag did not override window tag");

    sync_in_blank_a: assert property (
        (take && pix.blank) |=>
            hsyncOut == $past(pix.hsync) && vsyncOut == $past(pix.vsync))
        else $error("sync level wrong during blanking");

    pins_aligned_a: assert property (
        !(take || under) |=>
            $stable(pixelDataPins) && $stable(blankOut) &&
            $stable(hsyncOut) && $stable(vsyncOut))
        else $error("pixel outputs moved without a pixel slot");

    tag_enable_a: assert property (
        (wrAcc && paddr == OFF_CONFIG) |=>
            q.tagEn == $past(pwdata[TAG_EN_BIT]))
        else $error("tag enable bit not written");

    current_tag_a: assert property (
        (take && !pix.cursor) |=> q.lastTag == $past(pix.tag))
        else $error("status tag does not follow scanned window");

    underrun_set_a: assert property (
        under |=> q.underrun)
        else $error("underrun lost against clear");

    unmapped_err_a: assert property (
        (setup && !mapped) ##1 access |-> pslverr)
        else $error("unmapped address not refused");

endmodule : video_pixel_output
`default_nettype wire

// *** design/video_out_pkg.sv ***
// Shared constants and types of the video pixel output stage.
// Assumes one clock domain; register map is reached over APB.
package video_out_pkg;

    // ---------------------------------------------------------------
    // Pixel depth and stream word
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        DEPTH1,
        DEPTH2,
        DEPTH4,
        DEPTH8
    } depth_type;

    typedef struct packed {
        logic [7:0] bits;
        depth_type  depth;
        logic [1:0] tag;
        logic       cursor;
        logic       blank;
        logic       hsync;
        logic       vsync;
    } pixel_type;

    localparam int PIX_W         = $bits(pixel_type);
    localparam int BUF_DEPTH_DEF = 2;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int         ADDR_W      = 12;
    localparam logic [11:0] OFF_CONFIG = 12'h000;
    localparam logic [11:0] OFF_BLANKV = 12'h004;
    localparam logic [11:0] OFF_PAD    = 12'h008;
    localparam logic [11:0] OFF_CURTAG = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;

    localparam int TAG_EN_BIT    = 4;
    localparam int ST_UNDERRUN   = 0;
    localparam int ST_BLANK      = 1;
    localparam int ST_TAG_LSB    = 2;
    localparam int ST_FILL_LSB   = 4;

    localparam logic       TAG_EN_RST = 1'b0;
    localparam logic [7:0] BLANKV_RST = 8'h00;
    localparam logic [7:0] PAD_RST    = 8'h00;
    localparam logic [1:0] CURTAG_RST = 2'h0;

endpackage : video_out_pkg

// *** design/pixel_stream_if.sv ***
// Valid/ready carrier for pixel stream words between modules.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface pixel_stream_if #(
    parameter int WIDTH = 8
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pixel_stream_if
`default_nettype wire

// *** design/two_entry_buffer.sv ***
// Small FIFO with valid/ready on both sides.
// Assumes synchronous inputs on clk, async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
)(
    input  wire logic                       clk,
    input  wire logic                       rstn,
    pixel_stream_if.snk                     inPort,
    pixel_stream_if.src                     outPort,
    output logic [$clog2(DEPTH+1)-1:0]      fill
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               cnt;
    } buf_state_type;

    buf_state_type q;
    buf_state_type d;
    logic          push;
    logic          pop;

    assign inPort.ready  = (q.cnt != CW'(DEPTH));
    assign outPort.valid = (q.cnt != '0);
    assign outPort.data  = q.mem[q.rd];
    assign fill          = q.cnt;
    assign push          = inPort.valid && inPort.ready;
    assign pop           = outPort.valid && outPort.ready;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wr] = inPort.data;
            d.wr = (q.wr == PW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
        end
        if (pop)
        begin
            d.rd = (q.rd == PW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    no_overflow_a: assert property ( // buffer bound
        @(posedge clk) disable iff (!rstn) q.cnt <= CW'(DEPTH))
        else $error("buffer fill above depth");

    first_word_a: assert property ( // buffer order
        @(posedge clk) disable iff (!rstn)
        (push && q.cnt == '0) |=> outPort.data == $past(inPort.data))
        else $error("first word not at buffer head");

endmodule : two_entry_buffer
`default_nettype wire

// *** design/pixel_formatter.sv ***
// Places bitmap bits on the low pins and padding on the rest.
// Assumes depth and padding are stable while the word is taken.
`timescale 1ns/10ps
`default_nettype none
module pixel_formatter
    import video_out_pkg::*;
(
    input  wire depth_type  depth,
    input  wire logic [7:0] bits,
    input  wire logic [7:0] pad,
    output logic [7:0]      pins
);
    always_comb
    begin
        case (depth)
            DEPTH1:  pins = {pad[7:1], bits[0]};
            DEPTH2:  pins = {pad[7:2], bits[1:0]};
            DEPTH4:  pins = {pad[7:4], bits[3:0]};
            default: pins = bits;
        endcase
    end
endmodule : pixel_formatter
`default_nettype wire

// *** sim/palette_model.sv ***
// External colour palette at the far side of the pixel pins.
// Assumes the pins, blank and syncs are sampled on the video clock.
`timescale 1ns/10ps
`default_nettype none
module palette_model
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  pixels,
    input  wire logic        blank,
    input  wire logic        hsync,
    input  wire logic        vsync,
    input  wire logic [15:0] hostColour,
    input  wire logic [1:0]  hostTagSel,
    input  wire logic        hostLoad,
    output logic             pending,
    output logic [15:0]      colour,
    output logic [11:0]      hybridColour
);
    logic [15:0] table_q [0:1023];
    logic [15:0] latch_q;
    logic [1:0]  tagSel_q;
    logic [1:0]  tags;
    // Hybrid entry: red, green, blue nibbles; latch bits 6:4 select
    logic [15:0][11:0] hybrid_q;

    // Tags are only meaningful while not blanked
    assign tags   = blank ? 2'h0 : {vsync, hsync};
    assign colour = blank ? 16'h0000 : table_q[{tags, pixels}];
    assign hybridColour = blank ? 12'h000 : hybrid_q[pixels[3:0]];

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pending <= 1'b0;
            hybrid_q <= '0;
        end
        else if (hostLoad)
        begin
            latch_q  <= hostColour;
            tagSel_q <= hostTagSel;
            pending  <= 1'b1;
        end
        else if (pending && blank && hsync)
        begin
            table_q[{tagSel_q, pixels}] <= latch_q;
            for (int c = 0; c < 3; c++)
                if (latch_q[4 + c])
                    hybrid_q[pixels[3:0]][4*c +: 4] <= latch_q[3:0];
            pending <= 1'b0;
        end
    end
endmodule : palette_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench of the video pixel output stage.
// Assumes the design package and a palette model at the pins.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import video_out_pkg::*;
    logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        inValid, inReady, inCursor, inBlank, inHsync, inVsync;
    logic [7:0]  inBits, pixelDataPins;
    logic [1:0]  inDepth, inTag, hostTagSel;
    logic        pixelAdvance, blankOut, hsyncOut, vsyncOut, hostLoad;
    logic        pending, er, rdy;
    logic [15:0] hostColour, colour;
    logic [11:0] hybridColour;
    int          miscompares, n_tests, n;

    video_pixel_output video_pixel_output_i (.core_clk(core_clk),
        .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .inValid(inValid),
        .inReady(inReady), .inBits(inBits), .inDepth(inDepth),
        .inTag(inTag), .inCursor(inCursor), .inBlank(inBlank),
        .inHsync(inHsync), .inVsync(inVsync),
        .pixelAdvance(pixelAdvance), .pixelDataPins(pixelDataPins),
        .blankOut(blankOut), .hsyncOut(hsyncOut), .vsyncOut(vsyncOut));
    palette_model palette_model_i (.clk(core_clk), .rstn(rstn),
        .pixels(pixelDataPins), .blank(blankOut), .hsync(hsyncOut),
        .vsync(vsyncOut), .hostColour(hostColour),
        .hostTagSel(hostTagSel), .hostLoad(hostLoad),
        .pending(pending), .colour(colour),
        .hybridColour(hybridColour));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
            rdy = pready; rd = prdata; er = pslverr;
        end while (rdy !== 1'b1 && n < 20);
        psel <= 1'b0; penable <= 1'b0;
        if (rdy !== 1'b1)
        begin
            miscompares++;
            test_done();
        end
    endtask : apb

    task automatic push(input logic [7:0] b, input logic [1:0] dp,
        input logic [1:0] tg, input logic cu, input logic bl,
        input logic hs, input logic vs);
        @(posedge core_clk);
        inValid <= 1'b1; inBits <= b; inDepth <= dp; inTag <= tg;
        inCursor <= cu; inBlank <= bl; inHsync <= hs; inVsync <= vs;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
            rdy = inReady;
        end while (rdy !== 1'b1 && n < 20);
        inValid <= 1'b0;
        if (rdy !== 1'b1)
        begin
            miscompares++;
            test_done();
        end
    endtask : push

    // One pixel slot, then the pin levels it produced
    task automatic adv(input logic [7:0] pins, input logic bl,
                       input logic hs, input logic vs);
        @(posedge core_clk);
        pixelAdvance <= 1'b1;
        @(posedge core_clk);
        pixelAdvance <= 1'b0;
        @(negedge core_clk);
        chk({21'h0, pixelDataPins, blankOut, hsyncOut, vsyncOut},
            {21'h0, pins, bl, hs, vs}, "pixel pins");
    endtask : adv

    function automatic logic [7:0] fmt(input logic [1:0] dp,
        input logic [7:0] b, input logic [7:0] pad);
        logic [7:0] m;
        m = (dp == 2'd0) ? 8'h01 : (dp == 2'd1) ? 8'h03 :
            (dp == 2'd2) ? 8'h0f : 8'hff;
        return (b & m) | (pad & ~m);
    endfunction : fmt

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial
    begin
        miscompares = 0; n_tests = 0;
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; inValid = 1'b0; inBits = 8'h00;
        inDepth = 2'h0; inTag = 2'h0; inCursor = 1'b0; inBlank = 1'b0;
        inHsync = 1'b0; inVsync = 1'b0; pixelAdvance = 1'b0;
        hostLoad = 1'b0; hostColour = 16'h0000; hostTagSel = 2'h0;
        @(negedge core_clk);
        chk({pixelDataPins, blankOut}, {8'h00, 1'b1}, "reset pins");
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        $display("test reset_and_map done");

        apb(1'b1, OFF_CONFIG, 32'h10);
        apb(1'b1, OFF_PAD, 32'ha5);
        apb(1'b1, OFF_CURTAG, 32'h2);
        for (int d = 0; d < 4; d++)
        begin
            push(8'h5a, 2'(d), 2'b01, 1'b0, 1'b0, 1'b0, 1'b0);
            adv(fmt(2'(d), 8'h5a, 8'ha5), 1'b0, 1'b1, 1'b0);
        end
        push(8'h5a, 2'd3, 2'b01, 1'b1, 1'b0, 1'b0, 1'b0);
        adv(8'h5a, 1'b0, 1'b0, 1'b1);
        apb(1'b1, OFF_BLANKV, 32'h3c);
        push(8'h5a, 2'd3, 2'b11, 1'b0, 1'b1, 1'b1, 1'b0);
        adv(8'h3c, 1'b1, 1'b1, 1'b0);
        apb(1'b1, OFF_CONFIG, 32'h0);
        push(8'h5a, 2'd3, 2'b11, 1'b1, 1'b0, 1'b0, 1'b0);
        adv(8'h5a, 1'b0, 1'b0, 1'b0);
        $display("test formats_and_tags done");

        push(8'h11, 2'd3, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0);
        push(8'h22, 2'd3, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0);
        @(negedge core_clk);
        chk({31'h0, inReady}, 32'h0, "buffer full");
        adv(8'h11, 1'b0, 1'b0, 1'b0);
        adv(8'h22, 1'b0, 1'b0, 1'b0);
        adv(8'h3c, 1'b1, 1'b0, 1'b0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk({31'h0, rd[ST_UNDERRUN]}, 32'h1, "underrun flag");
        apb(1'b1, OFF_STATUS, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk({31'h0, rd[ST_UNDERRUN]}, 32'h0, "underrun clear");
        $display("test buffer done");

        apb(1'b1, OFF_CONFIG, 32'h10);
        apb(1'b1, OFF_BLANKV, 32'h5a);
        chk({31'h0, pending}, 32'h0, "palette idle");
        @(posedge core_clk);
        hostLoad <= 1'b1; hostColour <= 16'hbeef; hostTagSel <= 2'b10;
        @(posedge core_clk);
        hostLoad <= 1'b0;
        push(8'h00, 2'd3, 2'b00, 1'b0, 1'b1, 1'b1, 1'b0);
        adv(8'h5a, 1'b1, 1'b1, 1'b0);
        n = 0;
        while (pending !== 1'b0 && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        chk({31'h0, pending}, 32'h0, "palette load done");
        push(8'h5a, 2'd3, 2'b10, 1'b0, 1'b0, 1'b0, 1'b0);
        adv(8'h5a, 1'b0, 1'b0, 1'b1);
        chk({16'h0, colour}, 32'hbeef, "palette colour");
        chk({20'h0, hybridColour}, 32'hff0, "hybrid colour");
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h8, "status fields");
        $display("test palette done");
        test_done();
    end
endmodule : tb
`default_nettype wire
